// ---- msr_regs.sv ----
// Function
// - An 8-bit read/write scratch register with no hardware effect resets to one for passing messages.
// - An unconfigured pin with global direction output and global enable set is driven with the global output value.
// - The global pair {dir,en} decodes 00 functional out, 10 tri-state, 01 forced out, 11 forced in.
// - Per-pin direction and enable settings override the global ones for the same pin.
// - Pin 9 carries its local value only when enabled, set as output and not under remote control.
// - Pin 9's pair {dir,en} decodes 00 functional out, 10 tri-state, 01 GPIO out, 11 GPIO in.
// - A write with byte lane 0 enabled to the meter register starts a count of pixel-clock edges over an interval set by the value.
// - The interval lasts the written value times the 40 ns oscillator period.
// - Reading the meter returns the edge count of the latest interval, not the written value.
// - The edge count saturates and holds at 0xff.
// - A status bit reads one in dual-link mode and zero in single-link mode.
// - A status bit reads one while the audio-clock PLL is locked, else zero.
// - A status bit reads one while the deserializer recovery is locked, else zero.
// - In dual-link mode the lock bit reads one only if both channels are locked.
`timescale 1ns/10ps
`default_nettype none
module msr_regs (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        pixel_clk_in,
  input  wire logic        pin9_in,
  output logic             pin9_out,
  output logic             pin9_oe_n,
  input  wire logic        pin9_func_value,
  input  wire logic        pin9_remote_value,
  input  wire logic        dual_link_active,
  input  wire logic        audio_pll_locked,
  input  wire logic        rx_lock_a,
  input  wire logic        rx_lock_b,
  output logic             irq
);

  function automatic msr_pkg::msr_reg_t reg_decode(input logic [7:0] addr);
    msr_pkg::msr_reg_t sel;
    sel = msr_pkg::R_NONE;
    if (addr[1:0] == 2'h0) begin
      case (addr[7:2])
        msr_pkg::IDX_SCRATCH:  sel = msr_pkg::R_SCR;
        msr_pkg::IDX_IOCFG:    sel = msr_pkg::R_IOCFG;
        msr_pkg::IDX_METER:    sel = msr_pkg::R_METER;
        msr_pkg::IDX_STATUS:   sel = msr_pkg::R_STAT;
        msr_pkg::IDX_IRQ_STAT: sel = msr_pkg::R_ISTAT;
        msr_pkg::IDX_IRQ_MASK: sel = msr_pkg::R_IMASK;
        msr_pkg::IDX_AUX:      sel = msr_pkg::R_AUX;
        default:               sel = msr_pkg::R_NONE;
      endcase
    end
    return sel;
  endfunction

  // Synchronisers for everything arriving from pins
  logic [msr_pkg::SY_W-1:0] sync_raw;
  logic [msr_pkg::SY_W-1:0] sync1_ff;
  logic [msr_pkg::SY_W-1:0] sync2_ff;

  assign sync_raw = {rx_lock_b, rx_lock_a, audio_pll_locked, dual_link_active, pin9_in, pixel_clk_in};

  genvar gi;
  generate
    for (gi = 0; gi < msr_pkg::SY_W; gi++) begin : g_sync
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          sync1_ff[gi] <= 1'b0;
          sync2_ff[gi] <= 1'b0;
        end else begin
          sync1_ff[gi] <= sync_raw[gi];
          sync2_ff[gi] <= sync1_ff[gi];
        end
      end
    end
  endgenerate

  logic pix_prev_ff;
  logic lock_prev_ff;
  logic dual_prev_ff;
  logic lock_now;
  logic pix_rise;

  // Both lanes must agree only while two lanes run
  assign lock_now = sync2_ff[msr_pkg::SY_DUAL] ? (sync2_ff[msr_pkg::SY_LOCKA] & sync2_ff[msr_pkg::SY_LOCKB])
                                               : sync2_ff[msr_pkg::SY_LOCKA];
  assign pix_rise = sync2_ff[msr_pkg::SY_PIX] & ~pix_prev_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pix_prev_ff  <= 1'b0;
      lock_prev_ff <= 1'b0;
      dual_prev_ff <= 1'b0;
    end else begin
      pix_prev_ff  <= sync2_ff[msr_pkg::SY_PIX];
      lock_prev_ff <= lock_now;
      dual_prev_ff <= sync2_ff[msr_pkg::SY_DUAL];
    end
  end

  // Write channel
  logic        aw_held_ff;
  logic [7:0]  awaddr_ff;
  logic        w_held_ff;
  logic [31:0] wdata_ff;
  logic        wlane0_ff;
  logic        awready_ff;
  logic        wready_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        aw_take;
  logic        w_take;
  logic        wr_fire;
  logic        nxt_aw_held;
  logic        nxt_w_held;
  logic        nxt_bvalid;
  msr_pkg::msr_reg_t wr_sel;

  assign aw_take     = s_axi_awvalid & awready_ff;
  assign w_take      = s_axi_wvalid & wready_ff;
  assign wr_fire     = aw_held_ff & w_held_ff & ~bvalid_ff;
  assign wr_sel      = reg_decode(awaddr_ff);
  assign nxt_aw_held = wr_fire ? 1'b0 : (aw_take | aw_held_ff);
  assign nxt_w_held  = wr_fire ? 1'b0 : (w_take | w_held_ff);
  assign nxt_bvalid  = wr_fire ? 1'b1 : (bvalid_ff & ~s_axi_bready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      awaddr_ff  <= 8'h00;
      wdata_ff   <= 32'h0000_0000;
      wlane0_ff  <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= msr_pkg::RESP_OKAY;
    end else begin
      aw_held_ff <= nxt_aw_held;
      w_held_ff  <= nxt_w_held;
      awready_ff <= ~nxt_aw_held & ~nxt_bvalid;
      wready_ff  <= ~nxt_w_held & ~nxt_bvalid;
      bvalid_ff  <= nxt_bvalid;
      if (aw_take) begin
        awaddr_ff <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_ff  <= s_axi_wdata;
        wlane0_ff <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        bresp_ff <= (wr_sel == msr_pkg::R_NONE) ? msr_pkg::RESP_SLVERR : msr_pkg::RESP_OKAY;
      end
    end
  end

  // Only lane 0 carries register data
  logic       wr_en;
  logic [7:0] wr_byte;
  assign wr_en   = wr_fire & wlane0_ff;
  assign wr_byte = wdata_ff[7:0];

  // Software registers
  logic [7:0]               scratch_ff;
  logic [7:0]               iocfg_ff;
  logic [msr_pkg::IRQ_W-1:0] imask_ff;
  logic                     remote_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scratch_ff <= msr_pkg::RST_SCRATCH;
    end else if (wr_en && wr_sel == msr_pkg::R_SCR) begin
      scratch_ff <= wr_byte;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      iocfg_ff <= msr_pkg::RST_IOCFG;
    end else if (wr_en && wr_sel == msr_pkg::R_IOCFG) begin
      iocfg_ff <= wr_byte;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      imask_ff  <= msr_pkg::RST_IRQ;
      remote_ff <= msr_pkg::RST_AUX;
    end else if (wr_en) begin
      if (wr_sel == msr_pkg::R_IMASK) begin
        imask_ff <= wr_byte[msr_pkg::IRQ_W-1:0];
      end
      if (wr_sel == msr_pkg::R_AUX) begin
        remote_ff <= wr_byte[msr_pkg::AUX_REMOTE];
      end
    end
  end

  // Pixel-clock meter; sampled clock must stay below half of aclk
  msr_pkg::msr_meter_st_t  mtr_st_ff;
  logic [msr_pkg::SPAN_W-1:0] span_ff;
  logic [7:0]              count_ff;
  logic                    meter_done;
  logic                    meter_start;

  assign meter_start = wr_en && wr_sel == msr_pkg::R_METER;
  assign meter_done  = (mtr_st_ff == msr_pkg::MTR_RUN) && (span_ff == '0) && !meter_start;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mtr_st_ff <= msr_pkg::MTR_IDLE;
      span_ff   <= '0;
      count_ff  <= msr_pkg::RST_METER;
    end else if (meter_start) begin
      // A new write restarts any measurement in flight
      mtr_st_ff <= msr_pkg::MTR_RUN;
      span_ff   <= msr_pkg::SPAN_W'(wr_byte * msr_pkg::OSC_CYCLES);
      count_ff  <= 8'h00;
    end else begin
      case (mtr_st_ff)
        msr_pkg::MTR_RUN: begin
          if (span_ff == '0) begin
            mtr_st_ff <= msr_pkg::MTR_IDLE;
          end else begin
            span_ff <= span_ff - 1'b1;
            if (pix_rise && count_ff != 8'hff) begin
              count_ff <= count_ff + 8'h01;
            end
          end
        end
        default: begin
          mtr_st_ff <= msr_pkg::MTR_IDLE;
        end
      endcase
    end
  end

  // Pin 9 pad control
  msr_pkg::msr_pad_mode_t pin_mode;
  msr_pkg::msr_pad_mode_t glob_mode;
  logic                   nxt_pin_out;
  logic                   nxt_pin_oe_n;
  logic                   pin_out_ff;
  logic                   pin_oe_n_ff;

  assign pin_mode  = msr_pkg::msr_pad_mode_t'({iocfg_ff[msr_pkg::IOCFG_PDIR], iocfg_ff[msr_pkg::IOCFG_PEN]});
  assign glob_mode = msr_pkg::msr_pad_mode_t'({iocfg_ff[msr_pkg::IOCFG_GDIR], iocfg_ff[msr_pkg::IOCFG_GEN]});

  always_comb begin
    nxt_pin_out  = 1'b0;
    nxt_pin_oe_n = 1'b1;
    case (pin_mode)
      msr_pkg::PAD_OUT: begin
        nxt_pin_oe_n = 1'b0;
        nxt_pin_out  = remote_ff ? pin9_remote_value : iocfg_ff[msr_pkg::IOCFG_PVAL];
      end
      msr_pkg::PAD_IN, msr_pkg::PAD_TRI: begin
        nxt_pin_oe_n = 1'b1;
      end
      default: begin
        // Pin left at functional: global settings take over
        case (glob_mode)
          msr_pkg::PAD_FUNC: begin
            nxt_pin_oe_n = 1'b0;
            nxt_pin_out  = pin9_func_value;
          end
          msr_pkg::PAD_OUT: begin
            nxt_pin_oe_n = 1'b0;
            nxt_pin_out  = iocfg_ff[msr_pkg::IOCFG_GVAL];
          end
          default: begin
            nxt_pin_oe_n = 1'b1;
          end
        endcase
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_out_ff  <= 1'b0;
      pin_oe_n_ff <= 1'b1;
    end else begin
      pin_out_ff  <= nxt_pin_out;
      pin_oe_n_ff <= nxt_pin_oe_n;
    end
  end

  // Live status, nothing stored
  logic [7:0] status_now;
  always_comb begin
    status_now                        = 8'h00;
    status_now[msr_pkg::STAT_RSV_ONE] = 1'b1;
    status_now[msr_pkg::STAT_DUAL]    = sync2_ff[msr_pkg::SY_DUAL];
    status_now[msr_pkg::STAT_AUDIO]   = sync2_ff[msr_pkg::SY_AUDIO];
    status_now[msr_pkg::STAT_LOCK]    = lock_now;
  end

  // Interrupts: set wins over a same-cycle write-one clear
  logic [msr_pkg::IRQ_W-1:0] istat_ff;
  logic [msr_pkg::IRQ_W-1:0] irq_set;
  logic [msr_pkg::IRQ_W-1:0] irq_clr;
  logic                      irq_ff;

  always_comb begin
    irq_set                    = '0;
    irq_set[msr_pkg::IRQ_METER] = meter_done;
    irq_set[msr_pkg::IRQ_LOCK]  = lock_prev_ff & ~lock_now;
    irq_set[msr_pkg::IRQ_MODE]  = dual_prev_ff ^ sync2_ff[msr_pkg::SY_DUAL];
    irq_clr                    = '0;
    if (wr_en && wr_sel == msr_pkg::R_ISTAT) begin
      irq_clr = wr_byte[msr_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      istat_ff <= msr_pkg::RST_IRQ;
      irq_ff   <= 1'b0;
    end else begin
      istat_ff <= (istat_ff & ~irq_clr) | irq_set;
      irq_ff   <= |(istat_ff & imask_ff);
    end
  end

  // Read channel
  logic        arready_ff;
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;
  logic        rd_take;
  logic        nxt_rvalid;
  logic [7:0]  rd_byte;
  msr_pkg::msr_reg_t rd_sel;

  assign rd_take    = s_axi_arvalid & arready_ff;
  assign rd_sel     = reg_decode(s_axi_araddr);
  assign nxt_rvalid = rd_take ? 1'b1 : (rvalid_ff & ~s_axi_rready);

  always_comb begin
    rd_byte = 8'h00;
    case (rd_sel)
      msr_pkg::R_SCR:   rd_byte = scratch_ff;
      msr_pkg::R_IOCFG: rd_byte = iocfg_ff;
      msr_pkg::R_METER: rd_byte = count_ff;
      msr_pkg::R_STAT:  rd_byte = status_now;
      msr_pkg::R_ISTAT: rd_byte = {5'h00, istat_ff};
      msr_pkg::R_IMASK: rd_byte = {5'h00, imask_ff};
      msr_pkg::R_AUX:   rd_byte = {3'h0, sync2_ff[msr_pkg::SY_PIN], 3'h0, remote_ff};
      default:          rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= msr_pkg::RESP_OKAY;
    end else begin
      arready_ff <= ~nxt_rvalid;
      rvalid_ff  <= nxt_rvalid;
      if (rd_take) begin
        rdata_ff <= {24'h00_0000, rd_byte};
        rresp_ff <= (rd_sel == msr_pkg::R_NONE) ? msr_pkg::RESP_SLVERR : msr_pkg::RESP_OKAY;
      end
    end
  end

  // Status has no write path, so writes to it only answer OKAY
  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
  assign pin9_out      = pin_out_ff;
  assign pin9_oe_n     = pin_oe_n_ff;
  assign irq           = irq_ff;

endmodule
`default_nettype wire

// ---- msr_pkg.sv ----
`default_nettype none
package msr_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_SCRATCH  = 6'h19;
  localparam logic [5:0] IDX_IOCFG    = 6'h1a;
  localparam logic [5:0] IDX_METER    = 6'h1b;
  localparam logic [5:0] IDX_STATUS   = 6'h1c;
  localparam logic [5:0] IDX_IRQ_STAT = 6'h20;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h21;
  localparam logic [5:0] IDX_AUX      = 6'h22;

  localparam logic [7:0] RST_SCRATCH  = 8'h01;
  localparam logic [7:0] RST_IOCFG    = 8'h00;
  localparam logic [7:0] RST_METER    = 8'h00;
  localparam logic [2:0] RST_IRQ      = 3'h0;
  localparam logic       RST_AUX      = 1'h0;

  localparam int IOCFG_GVAL = 7;
  localparam int IOCFG_GDIR = 5;
  localparam int IOCFG_GEN  = 4;
  localparam int IOCFG_PVAL = 3;
  localparam int IOCFG_PDIR = 1;
  localparam int IOCFG_PEN  = 0;

  localparam int STAT_RSV_ONE = 5;
  localparam int STAT_DUAL    = 4;
  localparam int STAT_AUDIO   = 3;
  localparam int STAT_LOCK    = 0;

  localparam int IRQ_METER = 0;
  localparam int IRQ_LOCK  = 1;
  localparam int IRQ_MODE  = 2;
  localparam int IRQ_W     = 3;

  localparam int AUX_REMOTE = 0;
  localparam int AUX_PIN_IN = 4;

  localparam int SY_PIX   = 0;
  localparam int SY_PIN   = 1;
  localparam int SY_DUAL  = 2;
  localparam int SY_AUDIO = 3;
  localparam int SY_LOCKA = 4;
  localparam int SY_LOCKB = 5;
  localparam int SY_W     = 6;

  localparam int ACLK_PERIOD_NS = 10;
  localparam int OSC_PERIOD_NS  = 40;
  localparam int OSC_CYCLES     = (OSC_PERIOD_NS + ACLK_PERIOD_NS - 1) / ACLK_PERIOD_NS;
  localparam int SPAN_W         = 10;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    PAD_FUNC = 2'b00,
    PAD_OUT  = 2'b01,
    PAD_TRI  = 2'b10,
    PAD_IN   = 2'b11
  } msr_pad_mode_t;

  typedef enum logic [0:0] {
    MTR_IDLE = 1'b0,
    MTR_RUN  = 1'b1
  } msr_meter_st_t;

  typedef enum logic [2:0] {
    R_NONE  = 3'b000,
    R_SCR   = 3'b001,
    R_IOCFG = 3'b010,
    R_METER = 3'b011,
    R_STAT  = 3'b100,
    R_ISTAT = 3'b101,
    R_IMASK = 3'b110,
    R_AUX   = 3'b111
  } msr_reg_t;
endpackage
`default_nettype wire

// ---- msr_regs_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none
module msr_regs_asserts (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        pin9_out,
  input wire logic        pin9_oe_n,
  input wire logic        pin9_func_value,
  input wire logic        pin9_remote_value,
  input wire logic        dual_link_active,
  input wire logic        audio_pll_locked,
  input wire logic        rx_lock_a,
  input wire logic        rx_lock_b
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [7:0] cfg_ff;
  logic       rem_ff;
  logic [1:0] cq_ff;
  logic [3:0] sts_ff;
  logic [2:0] sq_ff;
  logic       wr_go, rd_st, e_oe, e_val, e_lock;
  assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0];
  assign rd_st = s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h70;
  assign e_oe = (cfg_ff[1:0] == 2'h0) ? cfg_ff[5] : (cfg_ff[1:0] != 2'h1);
  assign e_val = (cfg_ff[1:0] == 2'h1) ? (rem_ff ? pin9_remote_value : cfg_ff[3]) :
                 (cfg_ff[4] ? cfg_ff[7] : pin9_func_value);
  assign e_lock = rx_lock_a && (rx_lock_b || !dual_link_active);
  // Shadow assumes address and data taken at one edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_ff <= 8'h00;
      rem_ff <= 1'b0;
      cq_ff <= 2'h0;
    end else if (wr_go && s_axi_awaddr == 8'h68) begin
      cfg_ff <= s_axi_wdata[7:0];
      cq_ff <= 2'h0;
    end else if (wr_go && s_axi_awaddr == 8'h88) begin
      rem_ff <= s_axi_wdata[0];
      cq_ff <= 2'h0;
    end else if (cq_ff != 2'h3) begin
      cq_ff <= cq_ff + 2'h1;
    end
  end
  // Async levels need time through the synchronisers
  always_ff @(posedge aclk) begin
    sts_ff <= {dual_link_active, audio_pll_locked, rx_lock_a, rx_lock_b};
    if (!aresetn || sts_ff != {dual_link_active, audio_pll_locked, rx_lock_a, rx_lock_b}) begin
      sq_ff <= 3'h0;
    end else if (sq_ff != 3'h7) begin
      sq_ff <= sq_ff + 3'h1;
    end
  end
  pin_enable_map_a: assert property (cq_ff == 2'h3 |-> pin9_oe_n == e_oe)
    else $error("pin9 enable mismatch");
  pin_value_map_a: assert property (cq_ff == 2'h3 && !e_oe |-> pin9_out == $past(e_val))
    else $error("pin9 value mismatch");
  lock_bit_a: assert property (rd_st && sq_ff > 3'h4 |=> s_axi_rdata[0] == $past(e_lock))
    else $error("lock bit mismatch");
  dual_bit_a: assert property (rd_st && sq_ff > 3'h4 |=> s_axi_rdata[4] == $past(dual_link_active))
    else $error("dual bit mismatch");
  audio_bit_a: assert property (rd_st && sq_ff > 3'h4 |=> s_axi_rdata[3] == $past(audio_pll_locked))
    else $error("audio bit mismatch");
  status_fixed_a: assert property (rd_st |=> s_axi_rdata[31:5] == 27'h1 && s_axi_rdata[2:1] == 2'h0)
    else $error("status fixed bits wrong");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  bad_addr_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[1:0] != 2'h0 |=>
                               s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("misaligned read not refused");
endmodule
bind msr_regs msr_regs_asserts msr_regs_asserts_inst (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .pin9_out(pin9_out), .pin9_oe_n(pin9_oe_n),
  .pin9_func_value(pin9_func_value), .pin9_remote_value(pin9_remote_value),
  .dual_link_active(dual_link_active), .audio_pll_locked(audio_pll_locked),
  .rx_lock_a(rx_lock_a), .rx_lock_b(rx_lock_b)
);
`default_nettype wire

// ---- misc_status_gpio_freq_regs_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module misc_status_gpio_freq_regs_tb_top;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        arvalid = 1'b0;
  logic        bready = 1'b0;
  logic        rready = 1'b0;
  logic        pix = 1'b0;
  logic        pin_in = 1'b0;
  logic        func_v = 1'b0;
  logic        rem_v = 1'b0;
  logic [3:0]  sts = 4'h0;
  logic        awready, wready, bvalid, arready, rvalid, pin_out, pin_oe_n, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [7:0]  lfsr = 8'h47;
  logic [7:0]  amap [10] = '{8'h64, 8'h68, 8'h6c, 8'h70, 8'h80, 8'h84, 8'h88, 8'h00, 8'h65, 8'hfc};
  int          n_errors, checks, cyc, pc, m_cfg, m_aux, m_irq, m_msk, m_met, bst;
  int          per = 4;
  int          m_scr = 1;

  msr_regs msr_regs_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pixel_clk_in(pix), .pin9_in(pin_in), .pin9_out(pin_out),
    .pin9_oe_n(pin_oe_n), .pin9_func_value(func_v), .pin9_remote_value(rem_v), .dual_link_active(sts[3]),
    .audio_pll_locked(sts[2]), .rx_lock_a(sts[1]), .rx_lock_b(sts[0]), .irq(irq)
  );

  always #5 aclk = ~aclk;
  // One pixel pulse per per cycles; period 3 overruns the count
  always @(posedge aclk) begin
    pc <= (pc + 1) % per;
    pix <= (pc == 0);
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end

  function automatic logic [7:0] nx(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  function automatic logic okaddr(input logic [7:0] a);
    return a inside {8'h64, 8'h68, 8'h6c, 8'h70, 8'h80, 8'h84, 8'h88};
  endfunction
  function automatic logic [31:0] mexp(input logic [7:0] a);
    case (a)
      8'h64: return 32'(m_scr);
      8'h68: return 32'(m_cfg);
      8'h6c: return 32'(m_met);
      8'h70: return {26'h0, 1'b1, sts[3], sts[2], 2'h0, sts[1] & (sts[0] | !sts[3])};
      8'h80: return 32'(m_irq);
      8'h84: return 32'(m_msk);
      8'h88: return 32'(m_aux + (pin_in ? 16 : 0));
      default: return 32'h0;
    endcase
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    if (n_errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      ta = ta || awready;
      tw = tw || wready;
      awvalid <= !ta;
      wvalid <= !tw;
    end
    // Late ready proves the response stands until taken
    repeat (bst) @(posedge aclk);
    bready <= 1'b1;
    @(posedge aclk);
    while (!bvalid) @(posedge aclk);
    bready <= 1'b0;
    chk(32'(bresp), okaddr(a) ? 32'h0 : 32'h2);
    if (s[0]) case (a)
      8'h64: m_scr = d;
      8'h68: m_cfg = d;
      8'h80: m_irq = m_irq & ~int'(d);
      8'h84: m_msk = d & 8'h07;
      8'h88: m_aux = d & 8'h01;
      default: ;
    endcase
  endtask
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    @(posedge aclk);
    while (!arready) @(posedge aclk);
    arvalid <= 1'b0;
    repeat (bst) @(posedge aclk);
    rready <= 1'b1;
    @(posedge aclk);
    while (!rvalid) @(posedge aclk);
    rready <= 1'b0;
    chk(rdata, mexp(a));
    chk(32'(rresp), okaddr(a) ? 32'h0 : 32'h2);
  endtask
  task automatic meter(input int n, input int p, input int e);
    per = p;
    wr(8'h6c, n[7:0], 4'h1);
    m_met = e;
    repeat (n * 4 - 2) @(posedge aclk);
    chk(32'(irq), 32'h0);
    repeat (3) @(posedge aclk);
    chk(32'(irq), 32'h0);
    @(posedge aclk);
    m_irq = 1;
    chk(32'(irq), 32'(m_msk & 1));
    rd(8'h6c);
    rd(8'h80);
    wr(8'h80, 8'h01, 4'h1);
    @(posedge aclk);
    chk(32'(irq), 32'h0);
  endtask

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 10; i++) rd(amap[i]);
    for (int i = 0; i < 8; i++) begin
      lfsr = nx(lfsr);
      bst = int'(lfsr[2:1]);
      wr(8'h64, lfsr, {3'h0, lfsr[0]});
      rd(8'h64);
    end
    bst = 0;
    wr(8'h70, 8'hff, 4'h1);
    wr(8'h74, 8'h55, 4'h1);
    for (int i = 0; i < 10; i++) rd(amap[i]);
    // Last pass returns to all-low, so lock falls and mode toggles
    for (int i = 0; i < 17; i++) begin
      if (sts[1] & (sts[0] | !sts[3]) & !(i[1] & (i[0] | !i[3]))) m_irq = m_irq | 2;
      if (sts[3] != i[3]) m_irq = m_irq | 4;
      sts <= i[3:0];
      repeat (6) @(posedge aclk);
      rd(8'h70);
      rd(8'h80);
    end
    sts <= 4'h0;
    repeat (8) @(posedge aclk);
    wr(8'h80, 8'h07, 4'h1);
    rd(8'h80);
    for (int i = 0; i < 32; i++) begin
      lfsr = nx(lfsr);
      func_v <= lfsr[1];
      rem_v <= lfsr[2];
      pin_in <= lfsr[3];
      wr(8'h88, {7'h0, i[4]}, 4'h1);
      wr(8'h68, {lfsr[7:6], i[3:2], lfsr[5:4], i[1:0]}, 4'h1);
      repeat (2) @(posedge aclk);
      chk(32'(pin_oe_n), 32'(i[1:0] == 2'h0 ? i[3] : i[1:0] != 2'h1));
      if (i[1:0] == 2'h1 || (i[1:0] == 2'h0 && !i[3]))
        chk(32'(pin_out), 32'(i[1:0] == 2'h1 ? (i[4] ? rem_v : lfsr[5]) : (i[2] ? lfsr[7] : func_v)));
      rd(8'h88);
      rd(8'h68);
    end
    wr(8'h84, 8'h01, 4'h1);
    meter(5, 4, 5);
    wr(8'h6c, 8'hc8, 4'h1);
    meter(3, 4, 3);
    meter(255, 3, 255);
    wr(8'h84, 8'h00, 4'h1);
    meter(2, 4, 2);
    print_verdict();
  end
endmodule
`default_nettype wire
